/* File: logic/clock_ctrl_pkg.sv */
// Shared constants and carrier types for the clock output select and divide block
package clock_ctrl_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [9:0] IDX_TRIM_READ = 10'h074;
   localparam logic [9:0] IDX_LOAD_ADJ = 10'h077;
   localparam logic [9:0] IDX_SRC_SEL = 10'h07C;
   localparam logic [9:0] IDX_DIV_CTRL = 10'h07D;
   localparam logic [9:0] IDX_OVERRIDE = 10'h071;
   localparam logic [9:0] IDX_KEY = 10'h072;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int TRIM_LSB = 0;
   localparam int CAP_OUT_LSB = 4;
   localparam int CAP_IN_LSB = 0;
   localparam int SEL2_LSB = 5;
   localparam int SEL3_LSB = 3;
   localparam int SEL5_BIT = 0;
   localparam int SECOND_PLL_DIV_BIT = 7;
   localparam int THIRD_PLL_DIV_BIT = 6;
   localparam int SYS_DIV_LSB = 3;
   localparam int DIV3_BIT = 2;
   localparam int DIV2_BIT = 1;
   localparam int DIV5_BIT = 0;
   localparam int OVD_BIT = 0;
   localparam int KEY_LSB = 0;

   // ------------------------------------------------------------
   // Reset, forced and default values
   // ------------------------------------------------------------
   localparam logic [3:0] CAP_RST = 4'h0;
   localparam logic [1:0] SEL2_RST = 2'h0;
   localparam logic [1:0] SEL3_FORCED = 2'h2;
   localparam logic [1:0] SEL3_OVD_DEFAULT = 2'h0;
   localparam logic SEL5_FORCED = 1'h1;
   localparam logic SEL5_DEFAULT = 1'h0;
   localparam logic SECOND_PLL_DIV_RST = 1'h0;
   localparam logic THIRD_PLL_DIV_RST = 1'h1;
   localparam logic [1:0] SYS_DIV_RST = 2'h1;
   localparam logic DIV3_RST = 1'h0;
   localparam logic OUT_DIV_FORCED = 1'h1;
   localparam logic OUT_DIV_DEFAULT = 1'h0;
   localparam logic OVD_RST = 1'h0;
   // Unlock word for the trim read-back; value is arbitrary
   localparam logic [15:0] KEY_VALUE = 16'hA5C3;
   // Divide exponent used when the third output divider bit is 1
   localparam logic [2:0] THIRD_DIV_EXP = 3'h1;

   // ------------------------------------------------------------
   // Source codes and carriers
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_PLL = 2'b00,
      SRC_GPIO = 2'b01,
      SRC_ALT = 2'b10,
      SRC_RSVD = 2'b11
   } src_code_t;

   typedef struct packed {
      logic [1:0] sel;
      logic [2:0] exp;
   } path_cfg_t;

endpackage

/* File: logic/clock_out_path.sv */
// One clock output path: source pick, power-of-two divide, reserved gating
module clock_out_path import clock_ctrl_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Source levels and configuration
   input wire logic [3:0] src,
   input wire path_cfg_t cfg,
   // Output
   output logic clk_out
);

   typedef struct packed {
      logic prev;
      logic [3:0] cnt;
      logic out;
   } path_state_t;

   path_state_t path_reg, path_next;
   logic pick;

   // Sources are sampled at the core rate, so each must run well below it
   always_comb begin
      path_next = path_reg;
      pick = src[cfg.sel];
      path_next.prev = pick;
      if (cfg.sel == SRC_RSVD) begin
         path_next.cnt = 4'h0;
         path_next.out = 1'b0;
      end else begin
         if (pick && !path_reg.prev) begin
            path_next.cnt = path_reg.cnt + 4'h1;
         end
         if (cfg.exp == 3'h0) begin
            path_next.out = pick;
         end else begin
            path_next.out = path_next.cnt[2'(cfg.exp - 3'h1)];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         path_reg <= '0;
      end else begin
         path_reg <= path_next;
      end
   end

   assign clk_out = path_reg.out;

endmodule // clock_out_path

/* File: logic/clock_output_select_divide.sv */
// Clock output source select and divider control with APB register access
//
// Contract
// - The 5-bit crystal output trim is read-only, set by the device: 00h 8pF, 0.5pF a step.
// - Reading the crystal output trim needs the security key to be unlocked.
// - Signed 4-bit load adjusts at 7:4 (output pin) and 3:0 (input pin), both reset 0.
// - Second source at 6:5 resets 00: second PLL, general pin, oscillator, reserved.
// - Third source at 4:3 is held at 10 (FLL) and ignores writes while override is 0.
// - When override is 1 the third source defaults to 00 (third PLL) and takes writes.
// - Fifth source is bit 0 (0 oscillator, 1 FLL), led by the fifth pin without override.
// - Override 0 and fifth pin low force the fifth source to 1 and writes are ignored.
// - Override 0 and fifth pin high default the fifth source to 0 and leave it writable.
// - Override 1 defaults the fifth source to 0 whatever the pin and keeps it writable; with the pin already high the code keeps the current value.
// - PLL output dividers at bits 7 and 6 reset to 0 and 1; 0 divides by 2, 1 by 4.
// - System clock divider at 4:3 resets to 01; 00 by 1, 01 by 2, 10 by 4, 11 reserved.
// - Third output divider at bit 2 resets to 0; 0 passes the clock undivided.
// - Second output divider bit 1: locked at 1 without override, else default 0, writable.
// - Fifth output divider bit 0: locked at 1 without override, else default 0, writable.
//
// Design decision made here: the APB register port.
module clock_output_select_divide import clock_ctrl_pkg::*; (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_B,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Clock sources
   input wire logic SECOND_PLL,
   input wire logic THIRD_PLL,
   input wire logic FLL_CLK,
   input wire logic OSC_CLK,
   input wire logic SECOND_GENERAL_PIN,
   input wire logic THIRD_GENERAL_PIN,
   input wire logic FIFTH_GENERAL_PIN,
   // Automatic trim result
   input wire logic [4:0] TRIM_CAP_CODE,
   // Crystal load adjustments
   output logic [3:0] CRYSTAL_OUT_LOAD_ADJUST,
   output logic [3:0] CRYSTAL_IN_LOAD_ADJUST,
   // Clock outputs
   output logic SECOND_CLOCK_OUTPUT,
   output logic THIRD_CLOCK_OUTPUT,
   output logic FIFTH_CLOCK_OUTPUT,
   output logic SYSTEM_CLOCK
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] sel2;
      logic [1:0] sel3;
      logic sel5;
      logic second_pll_div;
      logic third_pll_div;
      logic [1:0] sys_div;
      logic div3;
      logic div2;
      logic div5;
      logic [3:0] cap_out;
      logic [3:0] cap_in;
      logic ovd;
      logic ovd_prev;
      logic wr5_prev;
      logic [4:0] trim;
      logic ready;
      logic slverr;
      logic [31:0] rdata;
   } ctl_state_t;

   ctl_state_t ctl_reg, ctl_next;
   logic [9:0] idx;
   logic done;
   logic wr;
   logic mapped;
   logic unlocked;
   logic wr5_now;
   logic [2:0] second_pll_exp;
   logic [2:0] third_pll_exp;
   logic [3:0] path_src [4];
   path_cfg_t path_cfg [4];
   logic [3:0] path_out;

   assign idx = PADDR[11:2];
   assign done = PSEL && PENABLE && ctl_reg.ready;
   assign wr = done && PWRITE;
   assign mapped = (idx == IDX_TRIM_READ) || (idx == IDX_LOAD_ADJ) ||
                   (idx == IDX_SRC_SEL) || (idx == IDX_DIV_CTRL) ||
                   (idx == IDX_OVERRIDE) || (idx == IDX_KEY);
   assign wr5_now = ctl_reg.ovd || FIFTH_GENERAL_PIN;

   // ------------------------------------------------------------
   // Security key
   // ------------------------------------------------------------
   key_guard u_key (
      .clk(CORE_CLK),
      .rst_b(RST_B),
      .wr_stb(wr && (idx == IDX_KEY)),
      .wr_key(PWDATA[KEY_LSB +: 16]),
      .unlocked(unlocked)
   );

   // ------------------------------------------------------------
   // Register file and override handling
   // ------------------------------------------------------------
   always_comb begin
      ctl_next = ctl_reg;
      // One wait state: ready rises in the cycle after the first access cycle
      ctl_next.ready = PSEL && PENABLE && !ctl_reg.ready;
      ctl_next.trim = TRIM_CAP_CODE;
      if (PSEL && PENABLE && !ctl_reg.ready) begin
         ctl_next.slverr = !mapped;
         ctl_next.rdata = 32'h0;
         if (!PWRITE) begin
            unique case (idx)
               IDX_TRIM_READ: begin
                  if (unlocked) begin
                     ctl_next.rdata[TRIM_LSB +: 5] = ctl_reg.trim;
                  end
               end
               IDX_LOAD_ADJ: begin
                  ctl_next.rdata[CAP_OUT_LSB +: 4] = ctl_reg.cap_out;
                  ctl_next.rdata[CAP_IN_LSB +: 4] = ctl_reg.cap_in;
               end
               IDX_SRC_SEL: begin
                  ctl_next.rdata[SEL2_LSB +: 2] = ctl_reg.sel2;
                  ctl_next.rdata[SEL3_LSB +: 2] = ctl_reg.sel3;
                  ctl_next.rdata[SEL5_BIT] = ctl_reg.sel5;
               end
               IDX_DIV_CTRL: begin
                  ctl_next.rdata[SECOND_PLL_DIV_BIT] = ctl_reg.second_pll_div;
                  ctl_next.rdata[THIRD_PLL_DIV_BIT] = ctl_reg.third_pll_div;
                  ctl_next.rdata[SYS_DIV_LSB +: 2] = ctl_reg.sys_div;
                  ctl_next.rdata[DIV3_BIT] = ctl_reg.div3;
                  ctl_next.rdata[DIV2_BIT] = ctl_reg.div2;
                  ctl_next.rdata[DIV5_BIT] = ctl_reg.div5;
               end
               IDX_OVERRIDE: ctl_next.rdata[OVD_BIT] = ctl_reg.ovd;
               IDX_KEY: ctl_next.rdata[0] = unlocked;
               default: ctl_next.rdata = 32'h0;
            endcase
         end
      end
      if (wr) begin
         unique case (idx)
            IDX_LOAD_ADJ: begin
               ctl_next.cap_out = PWDATA[CAP_OUT_LSB +: 4];
               ctl_next.cap_in = PWDATA[CAP_IN_LSB +: 4];
            end
            IDX_SRC_SEL: begin
               ctl_next.sel2 = PWDATA[SEL2_LSB +: 2];
               if (ctl_reg.ovd) begin
                  ctl_next.sel3 = PWDATA[SEL3_LSB +: 2];
               end
               if (wr5_now) begin
                  ctl_next.sel5 = PWDATA[SEL5_BIT];
               end
            end
            IDX_DIV_CTRL: begin
               ctl_next.second_pll_div = PWDATA[SECOND_PLL_DIV_BIT];
               ctl_next.third_pll_div = PWDATA[THIRD_PLL_DIV_BIT];
               ctl_next.sys_div = PWDATA[SYS_DIV_LSB +: 2];
               ctl_next.div3 = PWDATA[DIV3_BIT];
               if (ctl_reg.ovd) begin
                  ctl_next.div2 = PWDATA[DIV2_BIT];
                  ctl_next.div5 = PWDATA[DIV5_BIT];
               end
            end
            IDX_OVERRIDE: ctl_next.ovd = PWDATA[OVD_BIT];
            // Trim read-back and key words leave this state alone
            default: ctl_next.ovd = ctl_reg.ovd;
         endcase
      end
      // Forced values win over writes; defaults load on entry to the writable state
      ctl_next.ovd_prev = ctl_reg.ovd;
      ctl_next.wr5_prev = wr5_now;
      if (!ctl_reg.ovd) begin
         ctl_next.sel3 = SEL3_FORCED;
         ctl_next.div2 = OUT_DIV_FORCED;
         ctl_next.div5 = OUT_DIV_FORCED;
      end else if (!ctl_reg.ovd_prev) begin
         ctl_next.sel3 = SEL3_OVD_DEFAULT;
         ctl_next.div2 = OUT_DIV_DEFAULT;
         ctl_next.div5 = OUT_DIV_DEFAULT;
      end
      if (!wr5_now) begin
         ctl_next.sel5 = SEL5_FORCED;
      end else if (!ctl_reg.wr5_prev) begin
         ctl_next.sel5 = SEL5_DEFAULT;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ctl_reg <= '0;
         ctl_reg.sel2 <= SEL2_RST;
         ctl_reg.sel3 <= SEL3_FORCED;
         ctl_reg.sel5 <= SEL5_FORCED;
         ctl_reg.second_pll_div <= SECOND_PLL_DIV_RST;
         ctl_reg.third_pll_div <= THIRD_PLL_DIV_RST;
         ctl_reg.sys_div <= SYS_DIV_RST;
         ctl_reg.div3 <= DIV3_RST;
         ctl_reg.div2 <= OUT_DIV_FORCED;
         ctl_reg.div5 <= OUT_DIV_FORCED;
         ctl_reg.cap_out <= CAP_RST;
         ctl_reg.cap_in <= CAP_RST;
         ctl_reg.ovd <= OVD_RST;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   // ------------------------------------------------------------
   // Clock path configuration
   // ------------------------------------------------------------
   // PLL output divide by 2 or 4 folds into the path exponent
   assign second_pll_exp = ctl_reg.second_pll_div ? 3'h2 : 3'h1;
   assign third_pll_exp = ctl_reg.third_pll_div ? 3'h2 : 3'h1;

   always_comb begin
      path_src[0] = {1'b0, OSC_CLK, SECOND_GENERAL_PIN, SECOND_PLL};
      path_cfg[0].sel = ctl_reg.sel2;
      path_cfg[0].exp = {2'h0, ctl_reg.div2};
      if (ctl_reg.sel2 == SRC_PLL) begin
         path_cfg[0].exp = second_pll_exp + {2'h0, ctl_reg.div2};
      end
      path_src[1] = {1'b0, FLL_CLK, THIRD_GENERAL_PIN, THIRD_PLL};
      path_cfg[1].sel = ctl_reg.sel3;
      path_cfg[1].exp = ctl_reg.div3 ? THIRD_DIV_EXP : 3'h0;
      if (ctl_reg.sel3 == SRC_PLL) begin
         path_cfg[1].exp = third_pll_exp + path_cfg[1].exp;
      end
      path_src[2] = {2'h0, FLL_CLK, OSC_CLK};
      path_cfg[2].sel = {1'b0, ctl_reg.sel5};
      path_cfg[2].exp = {2'h0, ctl_reg.div5};
      path_src[3] = {3'h0, THIRD_PLL};
      path_cfg[3].sel = (ctl_reg.sys_div == 2'h3) ? SRC_RSVD : SRC_PLL;
      path_cfg[3].exp = third_pll_exp + {1'b0, ctl_reg.sys_div};
   end

   // ------------------------------------------------------------
   // Clock paths
   // ------------------------------------------------------------
   for (genvar g = 0; g < 4; g++) begin : g_path
      clock_out_path u_path (
         .clk(CORE_CLK),
         .rst_b(RST_B),
         .src(path_src[g]),
         .cfg(path_cfg[g]),
         .clk_out(path_out[g])
      );
   end

   assign SECOND_CLOCK_OUTPUT = path_out[0];
   assign THIRD_CLOCK_OUTPUT = path_out[1];
   assign FIFTH_CLOCK_OUTPUT = path_out[2];
   assign SYSTEM_CLOCK = path_out[3];
   assign PRDATA = ctl_reg.rdata;
   assign PREADY = ctl_reg.ready;
   assign PSLVERR = ctl_reg.slverr;
   assign CRYSTAL_OUT_LOAD_ADJUST = ctl_reg.cap_out;
   assign CRYSTAL_IN_LOAD_ADJUST = ctl_reg.cap_in;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_B);

   sequence access_first_s;
      PSEL && PENABLE && !PREADY;
   endsequence

   sequence locked_trim_read_s;
      access_first_s ##0 (!PWRITE && idx == IDX_TRIM_READ && !unlocked);
   endsequence

   // Override set for two edges, so no default load can mask the write
   sequence free_write_s;
      ctl_reg.ovd && ctl_reg.ovd_prev && wr;
   endsequence

   apb_one_wait_a: assert property (access_first_s |=> PREADY)
      else $error("pready did not follow the first access cycle");

   trim_track_a: assert property (1'b1 |=> ctl_reg.trim == $past(TRIM_CAP_CODE))
      else $error("trim read-back does not follow the trim code");

   trim_locked_a: assert property (locked_trim_read_s |=> PREADY && PRDATA == 32'h0)
      else $error("trim read while locked returned data");

   load_write_a: assert property (wr && idx == IDX_LOAD_ADJ |=>
         CRYSTAL_OUT_LOAD_ADJUST == $past(PWDATA[7:4]) &&
         CRYSTAL_IN_LOAD_ADJUST == $past(PWDATA[3:0]))
      else $error("load adjustment write not stored");

   sel2_write_a: assert property (wr && idx == IDX_SRC_SEL |=>
         ctl_reg.sel2 == $past(PWDATA[6:5]))
      else $error("second source select write not stored");

   sel3_lock_a: assert property (!ctl_reg.ovd |=> ctl_reg.sel3 == SEL3_FORCED)
      else $error("third source not held at FLL without override");

   sel3_default_a: assert property ($rose(ctl_reg.ovd) |=>
         ctl_reg.sel3 == SEL3_OVD_DEFAULT)
      else $error("third source did not default to third PLL");

   sel5_forced_a: assert property (!ctl_reg.ovd && !FIFTH_GENERAL_PIN |=> ctl_reg.sel5)
      else $error("fifth source not forced to FLL");

   sel5_default_a: assert property (!ctl_reg.wr5_prev && wr5_now |=> !ctl_reg.sel5)
      else $error("fifth source did not default to oscillator");

   div_lock_a: assert property (!ctl_reg.ovd |=> ctl_reg.div2 && ctl_reg.div5)
      else $error("output dividers not held at two without override");

   div_write_a: assert property (wr && idx == IDX_DIV_CTRL |=>
         ctl_reg.second_pll_div == $past(PWDATA[7]) && ctl_reg.sys_div == $past(PWDATA[4:3]))
      else $error("divider write not stored");

   sel3_write_a: assert property (free_write_s ##0 idx == IDX_SRC_SEL |=>
         ctl_reg.sel3 == $past(PWDATA[4:3]))
      else $error("third source select write not stored");

   sel5_write_a: assert property (free_write_s ##0 idx == IDX_SRC_SEL |=>
         ctl_reg.sel5 == $past(PWDATA[0]))
      else $error("fifth source select write not stored");

   div_free_a: assert property (free_write_s ##0 idx == IDX_DIV_CTRL |=>
         ctl_reg.div2 == $past(PWDATA[1]) && ctl_reg.div5 == $past(PWDATA[0]))
      else $error("output divider write not stored with override");

   div3_write_a: assert property (wr && idx == IDX_DIV_CTRL |=>
         ctl_reg.div3 == $past(PWDATA[2]) && ctl_reg.third_pll_div == $past(PWDATA[6]))
      else $error("third divider write not stored");

   reserved_gate_a: assert property ((ctl_reg.sel2 == SRC_RSVD)[*3] |->
         !SECOND_CLOCK_OUTPUT)
      else $error("reserved source did not hold output low");

   third_gate_a: assert property ((ctl_reg.sel3 == SRC_RSVD)[*3] |->
         !THIRD_CLOCK_OUTPUT)
      else $error("reserved third source did not hold output low");

   sys_gate_a: assert property ((ctl_reg.sys_div == 2'h3)[*3] |-> !SYSTEM_CLOCK)
      else $error("reserved system divider did not hold clock low");

endmodule // clock_output_select_divide

/* File: logic/key_guard.sv */
// Security key latch that gates the crystal trim read-back
module key_guard import clock_ctrl_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Key write
   input wire logic wr_stb,
   input wire logic [15:0] wr_key,
   // State
   output logic unlocked
);

   typedef struct packed {
      logic open;
   } key_state_t;

   key_state_t key_reg, key_next;

   // Any other word relocks, so a stray write cannot leave it open
   always_comb begin
      key_next = key_reg;
      if (wr_stb) begin
         key_next.open = (wr_key == KEY_VALUE);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         key_reg <= '0;
      end else begin
         key_reg <= key_next;
      end
   end

   assign unlocked = key_reg.open;

endmodule // key_guard

/* File: testbench/tb_top.sv */
// Self-checking bench for the clock output select and divide block
module tb_top import clock_ctrl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   typedef struct packed {
      logic rd;
      logic err;
      logic [31:0] data;
   } note_t;

   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr;
   logic second_pll = 1'b0, third_pll = 1'b0, fll_clk = 1'b0, osc_clk = 1'b0;
   logic second_pin = 1'b0, third_pin = 1'b0, fifth_pin = 1'b0;
   logic [4:0] trim_code = 5'h00;
   logic [3:0] out_adj, in_adj;
   logic clk2, clk3, clk5, sys_clk;
   int err_total = 0;
   int num_checks = 0;
   int seed = 86222;
   int cyc = 0;
   note_t note_q[$];
   note_t cur;

   clock_output_select_divide u_dut (
      .CORE_CLK(core_clk), .RST_B(rst_b),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SECOND_PLL(second_pll), .THIRD_PLL(third_pll), .FLL_CLK(fll_clk),
      .OSC_CLK(osc_clk), .SECOND_GENERAL_PIN(second_pin),
      .THIRD_GENERAL_PIN(third_pin), .FIFTH_GENERAL_PIN(fifth_pin),
      .TRIM_CAP_CODE(trim_code), .CRYSTAL_OUT_LOAD_ADJUST(out_adj),
      .CRYSTAL_IN_LOAD_ADJUST(in_adj), .SECOND_CLOCK_OUTPUT(clk2),
      .THIRD_CLOCK_OUTPUT(clk3), .FIFTH_CLOCK_OUTPUT(clk5), .SYSTEM_CLOCK(sys_clk)
   );

   initial begin
      forever #10 core_clk = ~core_clk;
   end

   // Distinct half periods let a count tell which source was picked
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      second_pll <= (cyc / 2) % 2;
      third_pll <= (cyc / 3) % 2;
      fll_clk <= (cyc / 4) % 2;
      osc_clk <= (cyc / 5) % 2;
      second_pin <= (cyc / 6) % 2;
      third_pin <= (cyc / 7) % 2;
   end

   // ------------------------------------------------------------
   // Compare and closing tasks
   // ------------------------------------------------------------
   task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, e, s);
      end
   endtask

   task automatic check_cnt(input string what, input int e, input int s);
      num_checks++;
      if (s > e + 1 || s < e - 1) begin
         err_total++;
         $display("BAD %s expected %0d seen %0d", what, e, s);
      end
   endtask

   task automatic conclude();
      // A note left behind means an answer that never came
      check_word("pending answers", 32'h0, 32'(note_q.size()));
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge core_clk);
      err_total++;
      conclude();
   end

   // ------------------------------------------------------------
   // APB master, notes the expected answer before each transfer
   // ------------------------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic err, input logic [31:0] e);
      int n;
      n = 0;
      note_q.push_back('{rd: ~wr, err: err, data: e});
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge core_clk);
      end
      if (n == 20) check_word("pready", 32'h1, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] i, input logic [31:0] d);
      apb(1'b1, {i, 2'b00}, d, 1'b0, 32'h0);
   endtask

   task automatic rd(input logic [9:0] i, input logic [31:0] e);
      apb(1'b0, {i, 2'b00}, 32'h0, 1'b0, e);
   endtask

   always @(posedge core_clk) begin
      if (psel && penable && pready === 1'b1) begin
         if (note_q.size() == 0) begin
            check_word("unexpected answer", 32'h0, 32'h1);
         end else begin
            cur = note_q.pop_front();
            check_word("pslverr", {31'h0, cur.err}, {31'h0, pslverr});
            if (cur.rd) check_word("prdata", cur.data, prdata);
         end
      end
   end

   // Counts rising edges of each output against the expected divide
   task automatic measure(input logic [7:0] s, input logic [7:0] d);
      int c2, c3, c5, cs, nx, q2, q3, qs, h2, h3;
      logic p2, p3, p5, ps;
      c2 = 0;
      c3 = 0;
      c5 = 0;
      cs = 0;
      nx = 0;
      h2 = s[6:5] == 2'h0 ? 2 : s[6:5] == 2'h1 ? 6 : 5;
      q2 = s[6:5] == 2'h3 ? 0 : (s[6:5] == 2'h0 ? (d[7] ? 4 : 2) : 1) * (d[1] ? 2 : 1);
      h3 = s[4:3] == 2'h0 ? 3 : s[4:3] == 2'h1 ? 7 : 4;
      q3 = s[4:3] == 2'h3 ? 0 : (s[4:3] == 2'h0 ? (d[6] ? 4 : 2) : 1)
           * (d[2] ? (1 << THIRD_DIV_EXP) : 1);
      qs = d[4:3] == 2'h3 ? 0 : (d[6] ? 4 : 2) * (1 << d[4:3]);
      repeat (12) @(posedge core_clk);
      {p2, p3, p5, ps} = {clk2, clk3, clk5, sys_clk};
      repeat (840) begin
         @(posedge core_clk);
         // Edge counts alone would let an unknown level pass as zero edges
         nx += int'($isunknown({clk2, clk3, clk5, sys_clk}));
         c2 += int'(clk2 && !p2);
         c3 += int'(clk3 && !p3);
         c5 += int'(clk5 && !p5);
         cs += int'(sys_clk && !ps);
         {p2, p3, p5, ps} = {clk2, clk3, clk5, sys_clk};
      end
      check_cnt("second output", q2 == 0 ? 0 : 840 / (2 * h2 * q2), c2);
      check_cnt("third output", q3 == 0 ? 0 : 840 / (2 * h3 * q3), c3);
      check_cnt("fifth output", 840 / (2 * (s[0] ? 4 : 5) * (d[0] ? 2 : 1)), c5);
      check_cnt("system clock", qs == 0 ? 0 : 840 / (6 * qs), cs);
      check_word("unknown clock levels", 32'h0, 32'(nx));
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0] v, s, d;
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      trim_code <= 5'($random(seed));
      rd(IDX_SRC_SEL, 32'h11);
      rd(IDX_DIV_CTRL, 32'h4B);
      rd(IDX_LOAD_ADJ, 32'h0);
      apb(1'b0, 12'h000, 32'h0, 1'b1, 32'h0);
      apb(1'b1, 12'h000, 32'hFFFF, 1'b1, 32'h0);
      wr(IDX_SRC_SEL, 32'h48);
      rd(IDX_SRC_SEL, 32'h51);
      wr(IDX_DIV_CTRL, 32'h0);
      rd(IDX_DIV_CTRL, 32'h03);
      repeat (4) begin
         v = 8'($random(seed));
         wr(IDX_LOAD_ADJ, {24'h0, v});
         rd(IDX_LOAD_ADJ, {24'h0, v});
         check_word("out adjust", {28'h0, v[7:4]}, {28'h0, out_adj});
         check_word("in adjust", {28'h0, v[3:0]}, {28'h0, in_adj});
      end
      rd(IDX_TRIM_READ, 32'h0);
      wr(IDX_KEY, {16'h0, KEY_VALUE});
      rd(IDX_KEY, 32'h1);
      rd(IDX_TRIM_READ, {27'h0, trim_code});
      wr(IDX_TRIM_READ, {27'h0, ~trim_code});
      rd(IDX_TRIM_READ, {27'h0, trim_code});
      wr(IDX_KEY, 32'h0);
      rd(IDX_KEY, 32'h0);
      rd(IDX_TRIM_READ, 32'h0);
      fifth_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(IDX_SRC_SEL, 32'h50);
      wr(IDX_SRC_SEL, 32'h41);
      rd(IDX_SRC_SEL, 32'h51);
      wr(IDX_SRC_SEL, 32'h40);
      rd(IDX_SRC_SEL, 32'h50);
      fifth_pin <= 1'b0;
      repeat (3) @(posedge core_clk);
      rd(IDX_SRC_SEL, 32'h51);
      wr(IDX_OVERRIDE, 32'h1);
      rd(IDX_SRC_SEL, 32'h40);
      rd(IDX_DIV_CTRL, 32'h00);
      rd(IDX_OVERRIDE, 32'h1);
      for (int i = 0; i < 16; i++) begin
         s = {1'b0, 2'(i), 2'(i >> 2), 2'b00, 1'($random(seed))};
         d = 8'($random(seed)) & 8'hC7;
         d[4:3] = 2'(i >> 1);
         fifth_pin <= 1'($random(seed));
         wr(IDX_SRC_SEL, {24'h0, s});
         wr(IDX_DIV_CTRL, {24'h0, d});
         rd(IDX_SRC_SEL, {24'h0, s});
         rd(IDX_DIV_CTRL, {24'h0, d});
         measure(s, d);
      end
      conclude();
   end
endmodule // tb_top
